// ==== core/bise_defs.svh ====
/*
 Constants of the branch/increment/OR/shift execute slice: widths,
 register offsets, field positions and reset values.
 Assumes inclusion by bare name from the package and the core module.
*/
`ifndef BISE_DEFS_SVH
`define BISE_DEFS_SVH

// ----------------------------------------
// Widths
// ----------------------------------------
`define BISE_PC_W 15
`define BISE_JUMP_W 11
`define BISE_LIT_W 8
`define BISE_FILE_W 7
`define BISE_BANK_W 5
`define BISE_ADDR_W 12
`define BISE_LATCH_W 7

// ----------------------------------------
// High latch slice feeding PC[14:11]
// ----------------------------------------
`define BISE_LATCH_HI 6
`define BISE_LATCH_LO 3

// ----------------------------------------
// APB register byte offsets
// ----------------------------------------
`define BISE_OFS_CTRL 12'h000
`define BISE_OFS_STATUS 12'h004
`define BISE_OFS_PC 12'h008

// ----------------------------------------
// Field positions
// ----------------------------------------
`define BISE_CTRL_RUN 0
`define BISE_STAT_ZERO 8
`define BISE_STAT_CARRY 9
`define BISE_STAT_NOP 10

// ----------------------------------------
// Reset values
// ----------------------------------------
`define BISE_RST_CTRL 1'h1
`define BISE_RST_PC 15'h0000
`define BISE_RST_ACC 8'h00

`endif

// ==== core/bise_pkg.sv ====
/*
 Types of the execute slice: operation codes, sequencer states and the
 instruction and file-write carriers.
 Assumes bise_defs.svh is on the include path.
*/
`include "bise_defs.svh"

package bise_pkg;

   // ----------------------------------------
   // Operations and states
   // ----------------------------------------
   typedef enum logic [5:0] {
      OP_JUMP_ABSOLUTE = 6'h01,
      OP_INCREMENT_FILE = 6'h02,
      OP_INCREMENT_SKIP_ZERO = 6'h04,
      OP_OR_LITERAL_INTO_ACC = 6'h08,
      OP_OR_ACC_WITH_FILE = 6'h10,
      OP_SHIFT_LEFT_LOGICAL = 6'h20
   } bise_op_t;

   typedef enum logic [1:0] {
      ST_EXEC = 2'h1,
      ST_FLUSH = 2'h2
   } bise_state_t;

   // ----------------------------------------
   // Carriers
   // ----------------------------------------
   typedef struct packed {
      bise_op_t op;
      logic toFile;
      logic [`BISE_FILE_W-1:0] fileSel;
      logic [`BISE_JUMP_W-1:0] literal;
   } bise_instr_t;

   typedef struct packed {
      logic we;
      logic [`BISE_ADDR_W-1:0] addr;
      logic [7:0] data;
   } bise_fwrite_t;

endpackage

// ==== core/bise_exec.sv ====
/*
 Execute slice of an 8-bit core: absolute jump, increment, increment
 and skip on zero, OR literal, OR with file, logical left shift. Holds
 the accumulator, zero and carry flags and the program counter, with a
 small APB slave for run control and state readback.
 Assumes instruction, file-read data and APB all come from logic on
 mclk; the register file reads combinationally from fileRdAddr.
*/
// Chosen here: the APB register port and the placing of the registers.
`include "bise_defs.svh"

module bise_exec (
   // Clock and reset
   input wire logic mclk,
   input wire logic rst_n,
   // Instruction issue
   input wire logic instrValid,
   input wire bise_pkg::bise_instr_t instr,
   output logic instrReady,
   // Core context
   input wire logic [`BISE_LATCH_W-1:0] programCounterHighLatch,
   input wire logic [`BISE_BANK_W-1:0] bankSel,
   // Register file
   output logic [`BISE_ADDR_W-1:0] fileRdAddr,
   input wire logic [7:0] fileRdData,
   output bise_pkg::bise_fwrite_t fileWr,
   // Core state
   output logic [`BISE_PC_W-1:0] pc,
   output logic [7:0] acc,
   output logic zeroFlag,
   output logic carryFlag,
   output logic nopCycle,
   // APB slave
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr
);
   import bise_pkg::*;

   // ----------------------------------------
   // Helpers
   // ----------------------------------------
   function automatic logic isZero(input logic [7:0] v);
      return v == 8'h00;
   endfunction

   function automatic logic [`BISE_ADDR_W-1:0] bankAddr(
      input logic [`BISE_BANK_W-1:0] b,
      input logic [`BISE_FILE_W-1:0] f);
      return {b, f};
   endfunction

   // ----------------------------------------
   // State
   // ----------------------------------------
   bise_state_t state, next_state;
   logic [`BISE_PC_W-1:0] next_pc;
   logic [7:0] next_acc;
   logic next_zeroFlag, next_carryFlag;
   bise_fwrite_t next_fileWr;
   logic run, next_run;
   logic [31:0] next_prdata;
   logic next_pslverr;
   logic take;
   logic [7:0] src;
   logic [7:0] res;

   // Operand read, with bypass of the write still in flight
   assign fileRdAddr = bankAddr(bankSel, instr.fileSel);
   assign src = (fileWr.we && fileWr.addr == fileRdAddr) ?
                fileWr.data : fileRdData;

   assign instrReady = run && state == ST_EXEC;
   assign take = instrValid && instrReady;
   assign nopCycle = state == ST_FLUSH;

   // ----------------------------------------
   // Execute
   // ----------------------------------------
   always_comb begin
      next_state = state;
      next_pc = pc;
      next_acc = acc;
      next_zeroFlag = zeroFlag;
      next_carryFlag = carryFlag;
      next_fileWr = '{we: 1'b0, addr: fileWr.addr, data: fileWr.data};
      res = 8'h00;
      unique case (state)
         ST_FLUSH: begin
            // Fetched word is discarded: this cycle is the NOP
            next_state = ST_EXEC;
         end
         ST_EXEC: begin
            if (take) begin
               next_pc = pc + `BISE_PC_W'(1);
               unique case (instr.op)
                  OP_JUMP_ABSOLUTE: begin
                     next_pc = {programCounterHighLatch[
                        `BISE_LATCH_HI:`BISE_LATCH_LO],
                        instr.literal};
                     next_state = ST_FLUSH;
                  end
                  OP_INCREMENT_FILE: begin
                     res = src + 8'h01;
                     next_zeroFlag = isZero(res);
                  end
                  OP_INCREMENT_SKIP_ZERO: begin
                     res = src + 8'h01;
                     if (isZero(res)) begin
                        next_pc = pc + `BISE_PC_W'(2);
                        next_state = ST_FLUSH;
                     end
                  end
                  OP_OR_LITERAL_INTO_ACC: begin
                     res = acc | instr.literal[`BISE_LIT_W-1:0];
                     next_zeroFlag = isZero(res);
                  end
                  OP_OR_ACC_WITH_FILE: begin
                     res = acc | src;
                     next_zeroFlag = isZero(res);
                  end
                  OP_SHIFT_LEFT_LOGICAL: begin
                     res = {src[6:0], 1'b0};
                     next_carryFlag = src[7];
                     next_zeroFlag = isZero(res);
                  end
                  default: begin
                     // Unknown code: advance only, touch nothing
                     next_pc = pc + `BISE_PC_W'(1);
                  end
               endcase
               // Destination select; literal OR always lands in acc
               if (instr.op inside {OP_INCREMENT_FILE,
                     OP_INCREMENT_SKIP_ZERO, OP_OR_ACC_WITH_FILE,
                     OP_SHIFT_LEFT_LOGICAL}) begin
                  if (instr.toFile) begin
                     next_fileWr = '{we: 1'b1, addr: fileRdAddr,
                                     data: res};
                  end else begin
                     next_acc = res;
                  end
               end else if (instr.op == OP_OR_LITERAL_INTO_ACC) begin
                  next_acc = res;
               end
            end
         end
         default: begin
            next_state = ST_EXEC;
         end
      endcase
   end

   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         state <= ST_EXEC;
         pc <= `BISE_RST_PC;
         acc <= `BISE_RST_ACC;
         zeroFlag <= 1'b0;
         carryFlag <= 1'b0;
         fileWr <= '0;
      end else begin
         state <= next_state;
         pc <= next_pc;
         acc <= next_acc;
         zeroFlag <= next_zeroFlag;
         carryFlag <= next_carryFlag;
         fileWr <= next_fileWr;
      end
   end

   // ----------------------------------------
   // APB slave
   // ----------------------------------------
   // Zero wait states: read data is staged in the setup cycle
   assign pready = psel && penable;

   always_comb begin
      next_run = run;
      next_prdata = prdata;
      next_pslverr = pslverr;
      if (psel && !penable) begin
         next_prdata = 32'h0000_0000;
         next_pslverr = 1'b0;
         unique case (paddr)
            `BISE_OFS_CTRL: begin
               next_prdata[`BISE_CTRL_RUN] = run;
            end
            `BISE_OFS_STATUS: begin
               next_prdata[7:0] = acc;
               next_prdata[`BISE_STAT_ZERO] = zeroFlag;
               next_prdata[`BISE_STAT_CARRY] = carryFlag;
               next_prdata[`BISE_STAT_NOP] = nopCycle;
            end
            `BISE_OFS_PC: begin
               next_prdata[`BISE_PC_W-1:0] = pc;
            end
            default: begin
               next_pslverr = 1'b1;
            end
         endcase
      end
      if (psel && penable && pwrite && paddr == `BISE_OFS_CTRL) begin
         next_run = pwdata[`BISE_CTRL_RUN];
      end
   end

   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         run <= `BISE_RST_CTRL;
         prdata <= 32'h0000_0000;
         pslverr <= 1'b0;
      end else begin
         run <= next_run;
         prdata <= next_prdata;
         pslverr <= next_pslverr;
      end
   end

endmodule

// ==== verification/bise_exec_props.sv ====
/*
 Checker for the execute slice: destination, flag and sequencing
 relations at the core's ports.
 Assumes it is bound onto every bise_exec instance.
*/
module bise_exec_props (
   // Clock, reset and issue
   input wire logic mclk,
   input wire logic rst_n,
   input wire logic instrValid,
   input wire bise_pkg::bise_instr_t instr,
   input wire logic instrReady,
   input wire logic [6:0] programCounterHighLatch,
   // File and core state
   input wire logic [7:0] fileRdData,
   input wire bise_pkg::bise_fwrite_t fileWr,
   input wire logic [14:0] pc,
   input wire logic [7:0] acc,
   input wire logic zeroFlag,
   input wire logic carryFlag,
   input wire logic nopCycle
);
   timeunit 1ns;
   timeprecision 1ns;
   import bise_pkg::*;
   default clocking @(posedge mclk); endclocking
   default disable iff (!rst_n);
   // ------
   // Helpers
   // ------
   logic go;
   logic fresh;
   bise_op_t op;
   assign go = instrValid && instrReady;
   // A pending write-back would be bypassed, so skip those cases
   assign fresh = go && !fileWr.we;
   assign op = instr.op;

   a_jump_low: assert property (
      go && op == OP_JUMP_ABSOLUTE |=> pc[10:0] == $past(instr.literal))
      else $error("jump low bits");
   a_jump_high: assert property (
      go && op == OP_JUMP_ABSOLUTE
      |=> pc[14:11] == $past(programCounterHighLatch[6:3]))
      else $error("jump high bits");
   a_jump_two_cycles: assert property (
      go && op == OP_JUMP_ABSOLUTE
      |=> (nopCycle && !instrReady && $stable(zeroFlag)
      && $stable(carryFlag)) ##1 !nopCycle)
      else $error("jump cycle count");
   a_inc_file: assert property (
      fresh && op == OP_INCREMENT_FILE && instr.toFile
      |=> fileWr.we && fileWr.data == $past(fileRdData) + 8'h01)
      else $error("increment result");
   a_dest_acc: assert property (
      go && !instr.toFile && op != OP_JUMP_ABSOLUTE |=> !fileWr.we)
      else $error("file written");
   a_skip_nop: assert property (
      fresh && op == OP_INCREMENT_SKIP_ZERO && fileRdData == 8'hFF
      |=> (nopCycle && !instrReady) ##1 !nopCycle)
      else $error("skip cycle");
   a_skip_flags: assert property (
      go && op == OP_INCREMENT_SKIP_ZERO
      |=> $stable(zeroFlag) && $stable(carryFlag))
      else $error("skip flags");
   a_or_literal: assert property (
      go && op == OP_OR_LITERAL_INTO_ACC
      |=> acc == ($past(acc) | $past(instr.literal[7:0])))
      else $error("or literal");
   a_or_file: assert property (
      fresh && op == OP_OR_ACC_WITH_FILE && !instr.toFile
      |=> acc == ($past(acc) | $past(fileRdData)))
      else $error("or file");
   a_shift_carry: assert property (
      fresh && op == OP_SHIFT_LEFT_LOGICAL
      |=> carryFlag == $past(fileRdData[7]))
      else $error("shift carry");
   a_zero_flag: assert property (
      go && op inside {OP_INCREMENT_FILE, OP_OR_LITERAL_INTO_ACC,
         OP_OR_ACC_WITH_FILE, OP_SHIFT_LEFT_LOGICAL}
      |=> zeroFlag == (fileWr.we ? fileWr.data == 8'h00 : acc == 8'h00))
      else $error("zero flag");
endmodule

bind bise_exec bise_exec_props u_bise_exec_props (.mclk, .rst_n,
   .instrValid, .instr, .instrReady, .programCounterHighLatch,
   .fileRdData, .fileWr, .pc, .acc, .zeroFlag, .carryFlag, .nopCycle);

// ==== verification/bise_exec_tb_top.sv ====
/*
 Self-checking bench for the execute slice: instruction table, jump,
 skip and APB cases. Assumes the core and its bound checker.
*/
module bise_exec_tb_top;
   timeunit 1ns;
   timeprecision 1ns;
   import bise_pkg::*;
   typedef struct {
      bise_op_t op;
      logic toFile;
      logic [7:0] lit, fd, res;
      logic z, c;
   } bise_row_t;
   logic mclk = 1'b0, rst_n = 1'b0, instrValid = 1'b0;
   logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
   logic instrReady, zeroFlag, carryFlag, nopCycle, pready, pslverr, err;
   bise_instr_t instr = '0;
   bise_fwrite_t fileWr;
   logic [6:0] programCounterHighLatch = 7'h5A;
   logic [4:0] bankSel = 5'h13;
   logic [7:0] fileRdData = 8'h00, acc;
   logic [11:0] paddr = 12'h000, fileRdAddr;
   logic [31:0] pwdata = 32'h0000_0000, prdata, q;
   logic [14:0] pc, expPc;
   int failCount = 0, numChecks = 0;
   bise_row_t rows[9] = '{
      '{OP_OR_LITERAL_INTO_ACC, 1'b0, 8'h00, 8'h00, 8'h00, 1'b1, 1'b0},
      '{OP_OR_LITERAL_INTO_ACC, 1'b0, 8'h5A, 8'h00, 8'h5A, 1'b0, 1'b0},
      '{OP_OR_ACC_WITH_FILE, 1'b0, 8'h00, 8'h81, 8'hDB, 1'b0, 1'b0},
      '{OP_OR_ACC_WITH_FILE, 1'b1, 8'h00, 8'h00, 8'hDB, 1'b0, 1'b0},
      '{OP_INCREMENT_FILE, 1'b0, 8'h00, 8'hFF, 8'h00, 1'b1, 1'b0},
      '{OP_INCREMENT_FILE, 1'b1, 8'h00, 8'h7F, 8'h80, 1'b0, 1'b0},
      '{OP_SHIFT_LEFT_LOGICAL, 1'b0, 8'h00, 8'h80, 8'h00, 1'b1, 1'b1},
      '{OP_SHIFT_LEFT_LOGICAL, 1'b1, 8'h00, 8'h41, 8'h82, 1'b0, 1'b0},
      '{OP_INCREMENT_SKIP_ZERO, 1'b1, 8'h00, 8'h10, 8'h11, 1'b0, 1'b0}};

   bise_exec u_bise_exec (.mclk, .rst_n, .instrValid, .instr, .instrReady,
      .programCounterHighLatch, .bankSel, .fileRdAddr, .fileRdData,
      .fileWr, .pc, .acc, .zeroFlag, .carryFlag, .nopCycle, .psel,
      .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr);

   initial forever #25 mclk = ~mclk;

   // ------
   // Tasks
   // ------
   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      numChecks++;
      if (seen !== exp) begin
         failCount++;
         $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask

   task automatic testDone;
      $display("checks %0d mismatches %0d", numChecks, failCount);
      if (failCount == 0 && numChecks > 0) begin
         $display("RESULT: PASS");
      end else begin
         $display("RESULT: FAIL");
      end
      $finish;
   endtask

   // Takes are two cycles apart, so no write-back bypass is hit;
   // the offer stands until the core is ready for it
   task automatic exec(input bise_op_t op, input logic f,
      input logic [10:0] k, input logic [7:0] fd);
      @(posedge mclk);
      instrValid <= 1'b1;
      instr <= '{op, f, 7'h55, k};
      fileRdData <= fd;
      do @(posedge mclk); while (instrReady !== 1'b1);
      instrValid <= 1'b0;
      #1;
   endtask

   task automatic apb(input logic w, input logic [11:0] a,
      input logic [31:0] d);
      @(posedge mclk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge mclk);
      penable <= 1'b1;
      do @(posedge mclk); while (pready !== 1'b1);
      q = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      // Let the access edge settle before anyone looks
      #1;
   endtask

   // Whole run is about 60 cycles; this allows many times that
   initial begin
      #100000;
      failCount++;
      testDone();
   end

   initial begin
      repeat (10) @(posedge mclk);
      rst_n <= 1'b1;
      #1;
      chk({pc, acc, zeroFlag, carryFlag, nopCycle}, 32'h0);
      chk({prdata[0], pslverr, fileWr.we, instrReady}, 32'h1);
      expPc = 15'h0000;
      foreach (rows[i]) begin
         exec(rows[i].op, rows[i].toFile, {3'h7, rows[i].lit}, rows[i].fd);
         expPc++;
         chk(rows[i].toFile ? fileWr.data : acc, rows[i].res);
         chk(fileWr.we, rows[i].toFile);
         chk(zeroFlag, rows[i].z);
         chk(carryFlag, rows[i].c);
         chk({nopCycle, pc}, expPc);
      end
      chk(fileWr.addr, 12'h9D5);
      chk(fileRdAddr, 12'h9D5);
      // Both flags set first, so a jump that touched them would show
      exec(OP_SHIFT_LEFT_LOGICAL, 1'b0, 11'h000, 8'h80);
      chk({zeroFlag, carryFlag}, 2'h3);
      // Latch bits 4:3 alone would give a different upper nibble
      exec(OP_JUMP_ABSOLUTE, 1'b0, 11'h7FF, 8'h00);
      chk(pc[10:0], 11'h7FF);
      chk(pc[14:11], 4'hB);
      chk({instrReady, nopCycle, zeroFlag, carryFlag}, 4'h7);
      // Zero cleared, carry kept: a skip that rewrote flags would show
      exec(OP_OR_LITERAL_INTO_ACC, 1'b0, 11'h001, 8'h00);
      expPc = 15'h6000;
      chk(pc, expPc);
      chk({zeroFlag, carryFlag, acc}, 10'h101);
      exec(OP_INCREMENT_SKIP_ZERO, 1'b0, 11'h000, 8'hFF);
      chk(pc, expPc + 15'h0002);
      chk({instrReady, nopCycle}, 2'h1);
      chk({zeroFlag, carryFlag, acc}, 10'h100);
      apb(1'b0, 12'h008, 32'h0000_0000);
      chk(q, {17'h0_0000, expPc + 15'h0002});
      apb(1'b0, 12'h004, 32'h0000_0000);
      chk(q, 32'h0000_0200);
      apb(1'b1, 12'h0FC, 32'hFFFF_FFFF);
      chk({err, q[30:0]}, 32'h8000_0000);
      apb(1'b1, 12'h000, 32'h0000_0000);
      chk(instrReady, 1'b0);
      apb(1'b1, 12'h000, 32'h0000_0001);
      chk(instrReady, 1'b1);
      // Back to back on one address: operand must come from the bypass
      @(posedge mclk);
      instrValid <= 1'b1;
      instr <= '{OP_INCREMENT_FILE, 1'b1, 7'h55, 11'h000};
      fileRdData <= 8'h10;
      repeat (2) begin
         do @(posedge mclk); while (instrReady !== 1'b1);
      end
      instrValid <= 1'b0;
      #1;
      chk(fileWr.data, 8'h12);
      chk(zeroFlag, 1'b0);
      // Stall first, so the mid-run reset must bring the run bit back
      apb(1'b1, 12'h000, 32'h0000_0000);
      @(posedge mclk);
      rst_n <= 1'b0;
      #1;
      chk({pc, acc, zeroFlag, carryFlag, nopCycle, fileWr.we}, 32'h0);
      @(posedge mclk);
      rst_n <= 1'b1;
      #1;
      chk({pslverr, instrReady}, 2'h1);
      testDone();
   end
endmodule
